// >>> hdl/rpt_timer.sv
// How it works
// RQ1 - 8-bit counter steps on prescaler tick
// RQ2 - software reads and writes live counter
// RQ3 - overflow reloads counter, prescaler untouched
// RQ4 - prescaler divides by two to n
// RQ5 - bit 7 picks cpu or external clock
// RQ6 - run bit off freezes prescaler and counter
// RQ7 - reset clears all, cpu clock selected
// RQ8 - force reload bit, always reads zero
// RQ9 - counter write also clears prescaler
// RQ10 - prescaler has no software access
// RQ11 - hidden compares load from duty on overflow
// RQ12 - output enable drives pin push-pull
// RQ13 - one shared period for all channels
// RQ14 - overflow sets level, compare restores it
// RQ15 - software sets duty above reload value
// RQ16 - waveforms stop in halt
// RQ17 - overflow flag, enable, cleared by read
// RQ18 - external events counted until overflow
// RQ19 - software stops counter before halt
// RQ20 - capture edge latches counter, sets flag
// RQ21 - capture blocked until its register read
// RQ22 - enabled capture edge wakes from halt
// RQ23 - polarity picks levels, acts at once
// RQ24 - sensitivity bit picks falling or rising
// RQ25 - pins synchronised and edge detected
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rpt_map.svh"

module rpt_timer #(
  parameter int ADDR_W = 12,
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_count_clock,
  input wire logic [NUM_CAP-1:0] capture_input_pin,
  input wire logic halt_mode,
  output logic [NUM_PWM-1:0] waveform_pin,
  output logic [NUM_PWM-1:0] waveform_oe,
  output logic overflow_irq,
  output logic [NUM_CAP-1:0] capture_irq,
  output logic halt_wake
);

  localparam int IDX_W = ADDR_W - 2;

  // ---------------- bus address phase ----------------
  logic acc_ok;
  logic [IDX_W-1:0] a_idx;
  logic rd_acc;
  logic wr_pend_q;
  logic [IDX_W-1:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  // hsize is not decoded: only whole-word transfers are expected
  assign acc_ok = hsel & htrans[1] & hready;
  assign a_idx = haddr[ADDR_W-1:2];
  assign rd_acc = acc_ok & ~hwrite;

  function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [7:0] reg_idx);
    hit = (idx == IDX_W'(reg_idx));
  endfunction

  // ---------------- registers ----------------
  rpt_pkg::rpt_byte_t ctrl_q;
  rpt_pkg::rpt_byte_t arr_q;
  rpt_pkg::rpt_byte_t cnt_q;
  logic [NUM_PWM-1:0] oe_q;
  logic [NUM_PWM-1:0] pol_q;
  logic [NUM_CAP-1:0] cap_sel_q;
  logic [NUM_CAP-1:0] cap_ie_q;
  logic [NUM_CAP-1:0] cap_flag_q;
  logic ovf_flag_q;
  rpt_pkg::rpt_byte_t duty_q [NUM_PWM];
  rpt_pkg::rpt_byte_t ocr_q [NUM_PWM];
  rpt_pkg::rpt_byte_t cap_val_q [NUM_CAP];

  logic wr_csr;
  logic wr_car;
  logic wr_arr;
  logic wr_out;
  logic wr_capcsr;
  logic force_reload;
  logic presc_clear;
  logic rd_csr;
  logic [NUM_CAP-1:0] rd_cap;

  assign wr_csr = wr_pend_q & hit(wr_idx_q, `RPT_IDX_CSR);
  assign wr_car = wr_pend_q & hit(wr_idx_q, `RPT_IDX_CAR);
  assign wr_arr = wr_pend_q & hit(wr_idx_q, `RPT_IDX_ARR);
  assign wr_out = wr_pend_q & hit(wr_idx_q, `RPT_IDX_OUTCTL);
  assign wr_capcsr = wr_pend_q & hit(wr_idx_q, `RPT_IDX_CAPCSR);
  // RQ8 - force reload strobe
  assign force_reload = wr_csr & hwdata[`RPT_CSR_FORCE_RELOAD];
  // RQ9 - prescaler cleared on init
  assign presc_clear = wr_car | force_reload;
  assign rd_csr = rd_acc & hit(a_idx, `RPT_IDX_CSR);
  assign rd_cap[0] = rd_acc & hit(a_idx, `RPT_IDX_CAP1);
  assign rd_cap[1] = rd_acc & hit(a_idx, `RPT_IDX_CAP2);

  // write data arrives one cycle after the address phase; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
    end else begin
      wr_pend_q <= acc_ok & hwrite;
      wr_idx_q <= a_idx;
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [`RPT_SYNC_STAGES-1:0] ext_sync_q;
  logic ext_last_q;
  logic ext_rise;

  // RQ25 - external clock synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_q <= '0;
      ext_last_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], external_count_clock};
      ext_last_q <= ext_sync_q[1];
    end
  end
  assign ext_rise = ext_sync_q[1] & ~ext_last_q;

  logic [NUM_CAP-1:0] cap_edge;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CAP; gc++) begin : g_cap
      logic [`RPT_SYNC_STAGES-1:0] sync_q;
      logic last_q;
      // RQ25 - capture pin synchronised
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_q <= '0;
          last_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[0], capture_input_pin[gc]};
          last_q <= sync_q[1];
        end
      end
      // RQ24 - edge sensitivity select
      assign cap_edge[gc] = cap_sel_q[gc] ? (sync_q[1] & ~last_q) : (~sync_q[1] & last_q);
    end
  endgenerate

  // ---------------- prescaler ----------------
  logic in_tick;
  logic presc_run;
  logic cnt_tick;

  // RQ5 - input clock select
  assign in_tick = ctrl_q[`RPT_CSR_EXTERNAL_CLOCK_SELECT] ? ext_rise : 1'b1;
  // RQ6 - run enable; nothing counts in halt
  assign presc_run = ctrl_q[`RPT_CSR_TCE] & ~halt_mode;

  // RQ10 - prescaler kept internal
  rpt_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_in(in_tick),
    .run(presc_run),
    .clear(presc_clear),
    .sel(ctrl_q[`RPT_CSR_CC_HI:`RPT_CSR_CC_LO]),
    .tick_out(cnt_tick)
  );

  // ---------------- counter ----------------
  logic ovf_evt;

  // RQ13 - one period shared by channels
  // RQ18 - overflow after events counted
  assign ovf_evt = cnt_tick & (cnt_q == `RPT_CNT_TOP) & ~wr_car & ~force_reload;

  // RQ1 - counter steps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `RPT_RST_BYTE;
    end else if (wr_car) begin
      // RQ2 - write on the fly
      cnt_q <= hwdata[7:0];
    end else if (force_reload) begin
      // RQ8 - forced reload
      cnt_q <= arr_q;
    end else if (ovf_evt) begin
      // RQ3 - reload on overflow
      cnt_q <= arr_q;
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ---------------- control registers ----------------
  // RQ7 - control resets to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RPT_RST_BYTE;
    end else if (wr_csr) begin
      // flag and force bits are not stored here
      ctrl_q <= hwdata[7:0] & 8'hFA;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arr_q <= `RPT_RST_BYTE;
    end else if (wr_arr) begin
      arr_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_q <= '0;
      pol_q <= '0;
    end else if (wr_out) begin
      oe_q <= hwdata[`RPT_OUT_OE_LO +: NUM_PWM];
      pol_q <= hwdata[`RPT_OUT_OP_LO +: NUM_PWM];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_sel_q <= '0;
      cap_ie_q <= '0;
    end else if (wr_capcsr) begin
      cap_sel_q <= hwdata[`RPT_CAP_CS_LO +: NUM_CAP];
      cap_ie_q <= hwdata[`RPT_CAP_CIE_LO +: NUM_CAP];
    end
  end

  // RQ17 - overflow flag, set wins over read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_q <= 1'b1;
    end else if (rd_csr) begin
      ovf_flag_q <= 1'b0;
    end
  end

  // RQ17 - overflow interrupt request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= (ovf_flag_q | ovf_evt) & ctrl_q[`RPT_CSR_OIE];
    end
  end

  // ---------------- pwm channels ----------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PWM; gp++) begin : g_pwm
      logic duty_wr;
      logic lvl;
      assign duty_wr = wr_pend_q & hit(wr_idx_q, 8'(`RPT_IDX_DUTY0 - 8'(gp)));

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          duty_q[gp] <= `RPT_RST_BYTE;
        end else if (duty_wr) begin
          duty_q[gp] <= hwdata[7:0];
        end
      end

      // RQ11 - double-buffered compare
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ocr_q[gp] <= `RPT_RST_BYTE;
        end else if (ovf_evt) begin
          ocr_q[gp] <= duty_q[gp];
        end
      end

      // RQ14 - level from count vs compare; RQ23 - polarity applied live
      assign lvl = (cnt_q <= ocr_q[gp]) ? ~pol_q[gp] : pol_q[gp];

      // RQ16 - output held in halt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          waveform_pin[gp] <= 1'b0;
        end else if (!halt_mode) begin
          // RQ12 - pin carries waveform only when enabled
          waveform_pin[gp] <= oe_q[gp] & lvl;
        end
      end

      // RQ12 - push-pull drive enable
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          waveform_oe[gp] <= 1'b0;
        end else begin
          waveform_oe[gp] <= oe_q[gp];
        end
      end
    end
  endgenerate

  // ---------------- capture channels ----------------
  logic [NUM_CAP-1:0] cap_take;
  logic wake_d;

  generate
    for (gc = 0; gc < NUM_CAP; gc++) begin : g_capch
      // RQ21 - blocked while flag set, unless read in the same cycle
      assign cap_take[gc] = cap_edge[gc] & (~cap_flag_q[gc] | rd_cap[gc]);

      // RQ20 - latch counter on edge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap_val_q[gc] <= `RPT_RST_BYTE;
        end else if (cap_take[gc]) begin
          cap_val_q[gc] <= cnt_q;
        end
      end

      // RQ21 - flag cleared by read, set wins
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap_flag_q[gc] <= 1'b0;
        end else if (cap_take[gc]) begin
          cap_flag_q[gc] <= 1'b1;
        end else if (rd_cap[gc]) begin
          cap_flag_q[gc] <= 1'b0;
        end
      end

      // RQ21 - pending while flag set
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          capture_irq[gc] <= 1'b0;
        end else begin
          capture_irq[gc] <= (cap_flag_q[gc] | cap_take[gc]) & cap_ie_q[gc];
        end
      end
    end
  endgenerate

  // RQ22 - enabled edge wakes from halt
  assign wake_d = halt_mode & (|(cap_edge & cap_ie_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_wake <= 1'b0;
    end else begin
      halt_wake <= wake_d;
    end
  end

  // ---------------- read mux ----------------
  rpt_pkg::rpt_byte_t rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (hit(a_idx, `RPT_IDX_CSR)) begin
      // RQ8 - force bit reads zero
      rd_val = {ctrl_q[7:3], 1'b0, ctrl_q[`RPT_CSR_OIE], ovf_flag_q};
    end else if (hit(a_idx, `RPT_IDX_CAR)) begin
      // RQ2 - live counter read
      rd_val = cnt_q;
    end else if (hit(a_idx, `RPT_IDX_ARR)) begin
      rd_val = arr_q;
    end else if (hit(a_idx, `RPT_IDX_OUTCTL)) begin
      rd_val = 8'({oe_q, pol_q});
    end else if (hit(a_idx, `RPT_IDX_CAPCSR)) begin
      rd_val = 8'({cap_sel_q, cap_ie_q, cap_flag_q});
    end else if (hit(a_idx, `RPT_IDX_CAP1)) begin
      rd_val = cap_val_q[0];
    end else if (hit(a_idx, `RPT_IDX_CAP2)) begin
      rd_val = cap_val_q[1];
    end else if (hit(a_idx, `RPT_IDX_DUTY0)) begin
      rd_val = duty_q[0];
    end else if (hit(a_idx, `RPT_IDX_DUTY1)) begin
      rd_val = duty_q[1];
    end else if (hit(a_idx, `RPT_IDX_DUTY2)) begin
      rd_val = duty_q[2];
    end else if (hit(a_idx, `RPT_IDX_DUTY3)) begin
      rd_val = duty_q[3];
    end
  end

  // read data is sampled at the address edge so it can leave a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_acc) begin
      hrdata_q <= {24'h000000, rd_val};
    end else begin
      hrdata_q <= 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;

endmodule

`default_nettype wire

// >>> shared/rpt_map.svh
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH

// register indices; byte address is four times the index
`define RPT_IDX_DUTY3 8'h73
`define RPT_IDX_DUTY2 8'h74
`define RPT_IDX_DUTY1 8'h75
`define RPT_IDX_DUTY0 8'h76
`define RPT_IDX_OUTCTL 8'h77
`define RPT_IDX_CSR 8'h78
`define RPT_IDX_CAR 8'h79
`define RPT_IDX_ARR 8'h7A
`define RPT_IDX_CAPCSR 8'h7B
`define RPT_IDX_CAP1 8'h7C
`define RPT_IDX_CAP2 8'h7D

// timer_control_status fields
`define RPT_CSR_EXTERNAL_CLOCK_SELECT 7
`define RPT_CSR_CC_HI 6
`define RPT_CSR_CC_LO 4
`define RPT_CSR_TCE 3
`define RPT_CSR_FORCE_RELOAD 2
`define RPT_CSR_OIE 1
`define RPT_CSR_OVF 0

// output_control_reg fields
`define RPT_OUT_OE_LO 4
`define RPT_OUT_OP_LO 0

// capture_control_status fields
`define RPT_CAP_CS_LO 4
`define RPT_CAP_CIE_LO 2
`define RPT_CAP_CF_LO 0

// reset values and timing
`define RPT_RST_BYTE 8'h00
`define RPT_CNT_TOP 8'hFF
`define RPT_SYNC_STAGES 2

`endif

// >>> shared/rpt_pkg.sv
package rpt_pkg;

  typedef logic [7:0] rpt_byte_t;
  typedef logic [2:0] rpt_presc_sel_t;

endpackage

// >>> hdl/rpt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module rpt_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick_in,
  input wire logic run,
  input wire logic clear,
  input wire rpt_pkg::rpt_presc_sel_t sel,
  output logic tick_out
);

  logic [6:0] div_q;
  logic [6:0] mask;

  // RQ4 - tap mask select
  assign mask = 7'((8'h01 << sel) - 8'h01);

  // RQ6 - frozen when stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 7'h00;
    end else if (clear) begin
      div_q <= 7'h00;
    end else if (run && tick_in) begin
      div_q <= div_q + 7'h01;
    end
  end

  // RQ4 - divide by two to n
  assign tick_out = run & tick_in & (&(div_q | ~mask));

endmodule

`default_nettype wire

// >>> test/rpt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rpt_chk #(
  parameter int ADDR_W = 12,
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic halt_mode,
  input wire logic [NUM_PWM-1:0] waveform_pin,
  input wire logic [NUM_PWM-1:0] waveform_oe,
  input wire logic overflow_irq,
  input wire logic [NUM_CAP-1:0] capture_irq,
  input wire logic halt_wake
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken;
  logic rd_taken;
  logic [3:0] csr_hist_q;
  logic [3:0] cap_hist_q;
  assign taken = hsel && htrans[1] && hready;
  assign rd_taken = taken && !hwrite;
  // an irq may only drop once software touched its register; writes land one cycle late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_hist_q <= 4'h0;
      cap_hist_q <= 4'h0;
    end else begin
      csr_hist_q <= {csr_hist_q[2:0], taken && haddr == 12'h1E0};
      cap_hist_q <= {cap_hist_q[2:0], taken && (haddr == 12'h1F0 || haddr == 12'h1EC)};
    end
  end
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_READY: assert property ($past(hresetn) |-> hreadyout)
    else $error("slave stalled the bus");
  AST_RDATA_HI: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_RDATA_SRC: assert property (hrdata != 32'h0 |-> $past(rd_taken))
    else $error("read data outside read data phase");
  AST_OVF_FALL: assert property ($fell(overflow_irq) |-> |csr_hist_q)
    else $error("overflow irq dropped without control access");
  AST_CAP_FALL: assert property ($fell(capture_irq[0]) |-> |cap_hist_q)
    else $error("capture irq dropped without read");
  AST_WAKE_ONE: assert property (halt_wake |=> !halt_wake)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_HALT: assert property (halt_wake |-> $past(halt_mode))
    else $error("wake pulse outside halt");
  AST_PIN_OFF: assert property ((waveform_pin & ~waveform_oe) == '0)
    else $error("disabled pwm pin driven high");
  cover property ($rose(overflow_irq));
  cover property ($rose(capture_irq[0]));
  cover property (halt_wake);
endmodule
bind rpt_timer rpt_chk #(.ADDR_W(ADDR_W), .NUM_PWM(NUM_PWM), .NUM_CAP(NUM_CAP)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_mode(halt_mode),
  .waveform_pin(waveform_pin), .waveform_oe(waveform_oe), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq), .halt_wake(halt_wake));
`default_nettype wire

// >>> test/rpt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpt_pin_model (
  input wire logic hclk,
  output logic external_count_clock,
  output logic [1:0] capture_input_pin
);
  initial begin
    external_count_clock = 1'b0;
    capture_input_pin = 2'b00;
  end
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      external_count_clock <= 1'b1;
      repeat (3) @(posedge hclk);
      external_count_clock <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask
  task automatic cap_set(input int ch, input logic v);
    @(posedge hclk);
    capture_input_pin[ch] <= v;
    repeat (6) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [11:0] A_OUT = 12'h1DC;
  localparam logic [11:0] A_CSR = 12'h1E0;
  localparam logic [11:0] A_CAR = 12'h1E4;
  localparam logic [11:0] A_ARR = 12'h1E8;
  localparam logic [11:0] A_CCS = 12'h1EC;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic halt_mode = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, external_count_clock, overflow_irq, halt_wake;
  logic [1:0] capture_input_pin, capture_irq;
  logic [3:0] waveform_pin, waveform_oe;
  logic [7:0] rd;
  int err_total = 0;
  int samples_checked = 0;
  int wake_cnt = 0;
  always #20 hclk = ~hclk;
  always @(posedge hclk) if (halt_wake === 1'b1) wake_cnt++;
  rpt_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_count_clock(external_count_clock), .capture_input_pin(capture_input_pin), .halt_mode(halt_mode),
    .waveform_pin(waveform_pin), .waveform_oe(waveform_oe), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq), .halt_wake(halt_wake));
  rpt_pin_model u_pins (.hclk(hclk), .external_count_clock(external_count_clock),
    .capture_input_pin(capture_input_pin));
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // values read right at the edge are the pre-edge ones, as the bus samples them
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic count_hi(output int hi[4]);
    hi = '{default: 0};
    repeat (40) begin
      @(posedge hclk);
      for (int i = 0; i < 4; i++) hi[i] += waveform_pin[i];
    end
  endtask
  task automatic t_regs();
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, (i < 11) ? 12'h1CC + 12'(4 * i) : 12'h000, 8'h00);
      chk("reset value", rd, 8'h00);
    end
    bus(1'b1, 12'h000, 8'hFF);
    rd_chk(12'h000, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_presc();
    bus(1'b1, A_CSR, 8'h78);
    bus(1'b1, A_CAR, 8'h10);
    rd_chk(A_CAR, 8'h10, "counter written");
    cyc(60);
    rd_chk(A_CAR, 8'h10, "before tick");
    cyc(120);
    rd_chk(A_CAR, 8'h11, "after 128");
    bus(1'b1, A_CSR, 8'h70);
    cyc(300);
    rd_chk(A_CAR, 8'h11, "counter frozen");
    rd_chk(A_CSR, 8'h70, "control");
    $display("test prescaler done");
  endtask
  task automatic t_pwm();
    int hi[4];
    int chg;
    logic [3:0] snap;
    bus(1'b1, A_ARR, 8'hFC);
    for (int i = 0; i < 4; i++) bus(1'b1, 12'h1D8 - 12'(4 * i), 8'hFC + 8'(i));
    bus(1'b1, A_OUT, 8'hF0);
    bus(1'b1, A_CSR, 8'h0E);
    cyc(10);
    rd_chk(A_CSR, 8'h0B, "flag set");
    cyc(6);
    chk("overflow irq", overflow_irq, 8'h01);
    count_hi(hi);
    for (int i = 0; i < 4; i++) chk("high count", 8'(hi[i]), 8'(10 * (i + 1)));
    chk("drive enable", waveform_oe, 8'h0F);
    bus(1'b1, A_OUT, 8'hF1);
    cyc(4);
    count_hi(hi);
    chk("inverted count", 8'(hi[0]), 8'd30);
    halt_mode <= 1'b1;
    cyc(3);
    snap = waveform_pin;
    chg = 0;
    repeat (20) begin
      @(posedge hclk);
      if (waveform_pin !== snap) chg++;
    end
    halt_mode <= 1'b0;
    chk("halt changes", 8'(chg), 8'h00);
    bus(1'b1, A_CSR, 8'h02);
    bus(1'b0, A_CSR, 8'h00);
    rd_chk(A_CSR, 8'h02, "flag cleared");
    cyc(2);
    chk("irq cleared", overflow_irq, 8'h00);
    $display("test pwm done");
  endtask
  task automatic t_ext();
    bus(1'b1, A_ARR, 8'hFD);
    bus(1'b1, A_CSR, 8'h8C);
    u_pins.ext_pulses(2);
    cyc(4);
    rd_chk(A_CSR, 8'h88, "two events");
    u_pins.ext_pulses(1);
    cyc(4);
    rd_chk(A_CSR, 8'h89, "third event");
    bus(1'b1, A_CSR, 8'h00);
    $display("test events done");
  endtask
  task automatic t_cap();
    bus(1'b1, A_CAR, 8'h42);
    bus(1'b1, A_CCS, 8'h1C);
    u_pins.cap_set(0, 1'b1);
    chk("capture irq", capture_irq, 8'h01);
    rd_chk(A_CCS, 8'h1D, "capture flag");
    bus(1'b1, A_CAR, 8'h55);
    u_pins.cap_set(0, 1'b0);
    u_pins.cap_set(0, 1'b1);
    rd_chk(12'h1F0, 8'h42, "capture held");
    rd_chk(A_CCS, 8'h1C, "flag read off");
    u_pins.cap_set(1, 1'b1);
    u_pins.cap_set(1, 1'b0);
    rd_chk(12'h1F4, 8'h55, "falling capture");
    halt_mode <= 1'b1;
    u_pins.cap_set(0, 1'b0);
    u_pins.cap_set(0, 1'b1);
    halt_mode <= 1'b0;
    chk("wake pulses", 8'(wake_cnt), 8'h01);
    $display("test capture done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    hresetn <= 1'b1;
    cyc(2);
    t_regs();
    t_presc();
    t_pwm();
    t_ext();
    t_cap();
    final_report();
  end
  initial begin
    #400000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
